// [rtl/stcl_cfg.svh]
`ifndef STCL_CFG_SVH
`define STCL_CFG_SVH

// ----------------------------------------------------------------------
// Control word geometry
// ----------------------------------------------------------------------
`define STCL_WORD_BITS        32
`define STCL_TAP_COUNT        4
`define STCL_DOB_COUNT        7
`define STCL_WEIGHT_BITS      3
`define STCL_COUNT_BITS       6
`define STCL_COUNT_MAX        6'h3F

// ----------------------------------------------------------------------
// Field positions, bit 0 is the first bit on the link (the MSB)
// ----------------------------------------------------------------------
`define STCL_HALF_CUR_BASE    0
`define STCL_ANALOG_BASE      4
`define STCL_DOB_EN_BASE      8
`define STCL_UNUSED_BIT_A     15
`define STCL_DOB_ASSIGN_BASE  16
`define STCL_UNUSED_BIT_B     23
`define STCL_CLK_SEL_BIT      24
`define STCL_SHORT_DLY_BIT    25
`define STCL_LONG_DLY_BIT     26
`define STCL_INVERT_BASE      27
`define STCL_UNUSED_BIT_C     31

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define STCL_WORD_RESET       32'h00000000
`define STCL_CLK_PERIOD_NS    10
`define STCL_SETTLE_NS        100
`define STCL_SETTLE_CYCLES    (`STCL_SETTLE_NS / `STCL_CLK_PERIOD_NS)
`define STCL_PATH_CYCLES      5

`endif

// [rtl/stcl_pkg.sv]
`include "stcl_cfg.svh"

package stcl_pkg;

	// ------------------------------------------------------------------
	// Shared types
	// ------------------------------------------------------------------
	// Control word, index 0 is the first bit shifted in
	typedef logic [0:`STCL_WORD_BITS-1] stcl_word_t;

	// Link phase of the loader
	typedef enum logic [1:0] {
		STCL_IDLE  = 2'b00,
		STCL_SHIFT = 2'b01,
		STCL_HOLD  = 2'b10
	} stcl_phase_t;

	// Synchroniser state, two stages for the three link wires
	typedef struct packed {
		logic [2:0] stage_one;
		logic [2:0] stage_two;
	} stcl_sync_state_t;

endpackage : stcl_pkg

// [rtl/stcl_sync.sv]
`timescale 1ns/1ps
`include "stcl_cfg.svh"

// Two flip-flop synchroniser for the serial clock, data and enable wires
module stcl_sync (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic [2:0] async_in,
	output logic      [2:0] sync_out
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	stcl_pkg::stcl_sync_state_t state;      // Both stages
	stcl_pkg::stcl_sync_state_t next_state; // Next value

	// Only the second stage is read; the first may be metastable
	always_comb begin
		next_state = state;
		next_state.stage_one = async_in;
		next_state.stage_two = state.stage_one;
	end

	// Stages clear to zero so an idle link reads as low
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign sync_out = state.stage_two;

endmodule : stcl_sync

// [rtl/stcl_decode.sv]
`timescale 1ns/1ps
`include "stcl_cfg.svh"

// Pure decode of the control word into the datapath controls
module stcl_decode (
	input  wire stcl_pkg::stcl_word_t          word,
	output logic [`STCL_TAP_COUNT-1:0]         half_current,
	output logic [`STCL_TAP_COUNT-1:0]         analog_on,
	output logic [`STCL_DOB_COUNT-1:0]         dob_enable,
	output logic [`STCL_DOB_COUNT-1:0]         dob_to_tap2,
	output logic                               clock_select,
	output logic                               short_parallel,
	output logic                               long_parallel,
	output logic [`STCL_TAP_COUNT-1:0]         invert,
	output logic [4*`STCL_WEIGHT_BITS-1:0]     tap_weight
);

	// ------------------------------------------------------------------
	// Field helpers
	// ------------------------------------------------------------------
	// Four-bit field: first bit is tap 4, so result bit i is tap i+1
	function automatic logic [`STCL_TAP_COUNT-1:0] tap_field(
		input stcl_pkg::stcl_word_t w,
		input int                   base
	);
		logic [`STCL_TAP_COUNT-1:0] f;
		f = '0;
		for (int i = 0; i < `STCL_TAP_COUNT; i++) begin
			f[i] = w[base + `STCL_TAP_COUNT - 1 - i];
		end
		return f;
	endfunction : tap_field

	// Seven-bit field: first bit is buffer 7, result bit i is buffer i+1
	function automatic logic [`STCL_DOB_COUNT-1:0] dob_field(
		input stcl_pkg::stcl_word_t w,
		input int                   base
	);
		logic [`STCL_DOB_COUNT-1:0] f;
		f = '0;
		for (int i = 0; i < `STCL_DOB_COUNT; i++) begin
			f[i] = w[base + `STCL_DOB_COUNT - 1 - i];
		end
		return f;
	endfunction : dob_field

	// Count of set bits, weight of a tap in eighths of full output
	function automatic logic [`STCL_WEIGHT_BITS-1:0] ones(
		input logic [`STCL_DOB_COUNT-1:0] v
	);
		logic [`STCL_WEIGHT_BITS-1:0] n;
		n = '0;
		for (int i = 0; i < `STCL_DOB_COUNT; i++) begin
			n = n + {{(`STCL_WEIGHT_BITS-1){1'b0}}, v[i]};
		end
		return n;
	endfunction : ones

	// ------------------------------------------------------------------
	// Decode; bits 15, 23 and 31 are never looked at
	// ------------------------------------------------------------------
	logic [`STCL_DOB_COUNT-1:0] on_tap2; // Active buffers sent to tap 2
	logic [`STCL_DOB_COUNT-1:0] on_alt;  // Active buffers on home tap

	always_comb begin
		half_current   = tap_field(word, `STCL_HALF_CUR_BASE);
		analog_on      = tap_field(word, `STCL_ANALOG_BASE);
		dob_enable     = dob_field(word, `STCL_DOB_EN_BASE);
		dob_to_tap2    = dob_field(word, `STCL_DOB_ASSIGN_BASE);
		clock_select   = word[`STCL_CLK_SEL_BIT];
		short_parallel = word[`STCL_SHORT_DLY_BIT];
		long_parallel  = word[`STCL_LONG_DLY_BIT];
		invert         = tap_field(word, `STCL_INVERT_BASE);
		on_tap2        = dob_enable & dob_to_tap2;
		on_alt         = dob_enable & ~dob_to_tap2;
		// Home taps: buffers 1-2 tap 1, 3-5 tap 3, 6-7 tap 4
		tap_weight[0 +: `STCL_WEIGHT_BITS] = ones(on_alt & 7'h03);
		tap_weight[3 +: `STCL_WEIGHT_BITS] = ones(on_tap2);
		tap_weight[6 +: `STCL_WEIGHT_BITS] = ones(on_alt & 7'h1C);
		tap_weight[9 +: `STCL_WEIGHT_BITS] = ones(on_alt & 7'h60);
	end

endmodule : stcl_decode

// [rtl/stcl_top.sv]
`timescale 1ns/1ps
`include "stcl_cfg.svh"


module stcl_top (
	input  wire logic                          clock,
	input  wire logic                          reset_n,
	input  wire logic                          serial_cfg_data_in,
	input  wire logic                          serial_cfg_clock_in,
	input  wire logic                          serial_cfg_write_enable,
	output logic [`STCL_TAP_COUNT-1:0]         half_current_on,
	output logic [`STCL_TAP_COUNT-1:0]         analog_section_on,
	output logic [`STCL_DOB_COUNT-1:0]         data_output_buffer_on,
	output logic [`STCL_DOB_COUNT-1:0]         data_output_buffer_tap2,
	output logic                               clock_out_select,
	output logic                               short_delay_parallel,
	output logic                               long_delay_parallel,
	output logic                               tap_one_invert,
	output logic                               tap_two_invert,
	output logic                               tap_three_invert,
	output logic                               tap_four_invert,
	output logic [`STCL_WEIGHT_BITS-1:0]       tap_one_weight,
	output logic [`STCL_WEIGHT_BITS-1:0]       tap_two_weight,
	output logic [`STCL_WEIGHT_BITS-1:0]       tap_three_weight,
	output logic [`STCL_WEIGHT_BITS-1:0]       tap_four_weight,
	output logic                               frame_active,
	output logic                               frame_complete,
	output logic [`STCL_COUNT_BITS-1:0]        frame_bit_count
);

	// ------------------------------------------------------------------
	// State of the loader
	// ------------------------------------------------------------------
	// Everything that holds a value lives in one packed record so that
	// the next-state logic below reads as a single transfer function.
	typedef struct packed {
		logic                              sclk_prev;  // Last synced clock
		stcl_pkg::stcl_phase_t             phase;      // Link phase
		stcl_pkg::stcl_word_t              word;       // Shift register
		logic [`STCL_COUNT_BITS-1:0]       count;      // Edges this frame
		logic                              complete;   // Last frame full
		logic [`STCL_TAP_COUNT-1:0]        half_cur;   // Registered out
		logic [`STCL_TAP_COUNT-1:0]        analog;     // Registered out
		logic [`STCL_DOB_COUNT-1:0]        dob_on;     // Registered out
		logic [`STCL_DOB_COUNT-1:0]        dob_t2;     // Registered out
		logic                              clk_sel;    // Registered out
		logic                              short_par;  // Registered out
		logic                              long_par;   // Registered out
		logic [`STCL_TAP_COUNT-1:0]        inv;        // Registered out
		logic [4*`STCL_WEIGHT_BITS-1:0]    weight;     // Registered out
	} stcl_core_state_t;

	stcl_core_state_t state;      // Current state
	stcl_core_state_t next_state; // Next state

	// ------------------------------------------------------------------
	// Link synchroniser
	// ------------------------------------------------------------------
	// All three wires come from the controller's domain, so each one
	// passes two flops before anything here looks at it. Data and clock
	// share the same delay, so the data seen at a detected edge is the
	// data that stood at that edge on the pins.
	logic [2:0] link_sync; // {enable, clock, data} after two stages

	stcl_sync u_sync (
		.clock    (clock),
		.reset_n  (reset_n),
		.async_in ({serial_cfg_write_enable,
		            serial_cfg_clock_in,
		            serial_cfg_data_in}),
		.sync_out (link_sync)
	);

	logic link_enable; // Synced write enable
	logic link_clock;  // Synced serial clock
	logic link_data;   // Synced serial data
	logic fall_edge;   // One-cycle pulse on a serial clock falling edge
	logic shift_now;   // Falling edge taken while enable is high

	assign link_enable = link_sync[2];
	assign link_clock  = link_sync[1];
	assign link_data   = link_sync[0];

	// Edge detector reads only the second stage and its own delayed copy
	assign fall_edge = state.sclk_prev & ~link_clock;
	// Edges with enable low are ignored, so the word is held
	assign shift_now = fall_edge & link_enable;

	// ------------------------------------------------------------------
	// Control decode
	// ------------------------------------------------------------------
	// The decode reads the live shift register, so the controls follow
	// the word bit by bit while a frame is shifting, just as a plain
	// shift register wired to the datapath would. A controller that
	// wants no intermediate patterns must keep the datapath quiet
	// until the enable drops.
	logic [`STCL_TAP_COUNT-1:0]      dec_half_cur;  // Decoded field
	logic [`STCL_TAP_COUNT-1:0]      dec_analog;    // Decoded field
	logic [`STCL_DOB_COUNT-1:0]      dec_dob_on;    // Decoded field
	logic [`STCL_DOB_COUNT-1:0]      dec_dob_t2;    // Decoded field
	logic                            dec_clk_sel;   // Decoded field
	logic                            dec_short_par; // Decoded field
	logic                            dec_long_par;  // Decoded field
	logic [`STCL_TAP_COUNT-1:0]      dec_inv;       // Decoded field
	logic [4*`STCL_WEIGHT_BITS-1:0]  dec_weight;    // Per-tap eighths

	stcl_decode u_decode (
		.word           (state.word),
		.half_current   (dec_half_cur),
		.analog_on      (dec_analog),
		.dob_enable     (dec_dob_on),
		.dob_to_tap2    (dec_dob_t2),
		.clock_select   (dec_clk_sel),
		.short_parallel (dec_short_par),
		.long_parallel  (dec_long_par),
		.invert         (dec_inv),
		.tap_weight     (dec_weight)
	);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_state.sclk_prev = link_clock;

		// New bits enter at the far end and older ones move toward
		// index 0, so after 32 edges the first bit sits in bit 0.
		// Further edges simply push the oldest bit out.
		if (shift_now) begin
			next_state.word = {state.word[1:`STCL_WORD_BITS-1],
			                   link_data};
			if (state.count != `STCL_COUNT_MAX) begin
				next_state.count = state.count + 6'h01;
			end
		end

		// Phase tracking: a frame opens on enable high and closes on
		// enable low; the bit count restarts with each new frame.
		case (state.phase)
			stcl_pkg::STCL_IDLE,
			stcl_pkg::STCL_HOLD: begin
				if (link_enable) begin
					next_state.phase = stcl_pkg::STCL_SHIFT;
					// An edge in the opening cycle is the frame's first
					next_state.count = shift_now ? 6'h01 : 6'h00;
				end
			end
			stcl_pkg::STCL_SHIFT: begin
				if (!link_enable) begin
					// Frame closed; flag it full when at least a word
					// arrived, since extra edges still leave one whole
					// word in the register
					next_state.phase    = stcl_pkg::STCL_HOLD;
					next_state.complete =
						(state.count >= 6'(`STCL_WORD_BITS));
				end else begin
					next_state.complete = 1'b0;
				end
			end
			default: begin
				// Unreachable code, fall back to a safe idle
				next_state.phase = stcl_pkg::STCL_IDLE;
			end
		endcase

		// Register every decoded control one stage after the word so
		// each output leaves a flop. Path from a pin edge to an output
		// is two sync stages, a combinational edge detect, the shift and
		// this stage, four cycles, well inside the settle budget.
		next_state.half_cur  = dec_half_cur;
		next_state.analog    = dec_analog;
		next_state.dob_on    = dec_dob_on;
		next_state.dob_t2    = dec_dob_t2;
		next_state.clk_sel   = dec_clk_sel;
		next_state.short_par = dec_short_par;
		next_state.long_par  = dec_long_par;
		next_state.inv       = dec_inv;
		next_state.weight    = dec_weight;
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// No reset value exists on the link side, so everything clears to
	// the all-off word: no taps, no buffers, main clock, opposite delays.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state       <= '0;
			state.word  <= `STCL_WORD_RESET;
			state.phase <= stcl_pkg::STCL_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, each straight from the state register
	// ------------------------------------------------------------------
	assign half_current_on         = state.half_cur;
	assign analog_section_on       = state.analog;
	assign data_output_buffer_on   = state.dob_on;
	assign data_output_buffer_tap2 = state.dob_t2;
	assign clock_out_select        = state.clk_sel;
	assign short_delay_parallel    = state.short_par;
	assign long_delay_parallel     = state.long_par;
	assign tap_one_invert          = state.inv[0];
	assign tap_two_invert          = state.inv[1];
	assign tap_three_invert        = state.inv[2];
	assign tap_four_invert         = state.inv[3];
	assign tap_one_weight          = state.weight[0 +: `STCL_WEIGHT_BITS];
	assign tap_two_weight          = state.weight[3 +: `STCL_WEIGHT_BITS];
	assign tap_three_weight        = state.weight[6 +: `STCL_WEIGHT_BITS];
	assign tap_four_weight         = state.weight[9 +: `STCL_WEIGHT_BITS];
	// Shift phase is the only code with bit 0 set, so this is a flop
	assign frame_active            = state.phase[0];
	assign frame_complete          = state.complete;
	assign frame_bit_count         = state.count;

endmodule : stcl_top

// [testbench/stcl_chk.sv]
`timescale 1ns/1ps
`include "stcl_cfg.svh"

// --------
// Port checker
// --------
module stcl_chk (
	input logic                             clock,
	input logic                             reset_n,
	input logic                             serial_cfg_data_in,
	input logic                             serial_cfg_clock_in,
	input logic                             serial_cfg_write_enable,
	input logic [`STCL_TAP_COUNT-1:0]       half_current_on,
	input logic [`STCL_TAP_COUNT-1:0]       analog_section_on,
	input logic [`STCL_DOB_COUNT-1:0]       data_output_buffer_on,
	input logic [`STCL_DOB_COUNT-1:0]       data_output_buffer_tap2,
	input logic                             clock_out_select,
	input logic                             short_delay_parallel,
	input logic                             long_delay_parallel,
	input logic                             tap_one_invert,
	input logic                             tap_two_invert,
	input logic                             tap_three_invert,
	input logic                             tap_four_invert,
	input logic [`STCL_WEIGHT_BITS-1:0]     tap_one_weight,
	input logic [`STCL_WEIGHT_BITS-1:0]     tap_two_weight,
	input logic [`STCL_WEIGHT_BITS-1:0]     tap_three_weight,
	input logic [`STCL_WEIGHT_BITS-1:0]     tap_four_weight,
	input logic                             frame_active,
	input logic                             frame_complete,
	input logic [`STCL_COUNT_BITS-1:0]      frame_bit_count
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	// All controls but the tap weights in one vector so stability is judged at once
	wire logic [28:0] ctl_bits = {half_current_on, analog_section_on,
		data_output_buffer_on, data_output_buffer_tap2, clock_out_select,
		short_delay_parallel, long_delay_parallel, tap_one_invert,
		tap_two_invert, tap_three_invert, tap_four_invert};
	// Active buffers on their home tap and on tap two
	wire logic [6:0]  home     = data_output_buffer_on & ~data_output_buffer_tap2;
	wire logic [6:0]  to_two   = data_output_buffer_on & data_output_buffer_tap2;
	// Cycles since a link clock fall; saturates so idle time stays quiet
	logic [3:0]       since_fall;

	// Age of the last falling edge on the link clock pin
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			since_fall <= 4'hF;
		end else if ($fell(serial_cfg_clock_in)) begin
			since_fall <= 4'h0;
		end else if (since_fall != 4'hF) begin
			since_fall <= since_fall + 4'h1;
		end
	end

	// An accepted link clock fall and a long quiet enable
	sequence seq_link_fall;
		$fell(serial_cfg_clock_in) && serial_cfg_write_enable;
	endsequence
	sequence seq_quiet;
		!serial_cfg_write_enable [*8];
	endsequence

	AST_RESET_CLEAR: assert property ($rose(reset_n) |->
		ctl_bits == '0 && frame_bit_count == 6'h00 && !frame_complete)
		else $error("controls not cleared by reset");
	AST_EDGE_COUNTED: assert property (seq_link_fall ##0
		frame_bit_count < 6'h3E |->
		##[2:5] frame_bit_count == $past(frame_bit_count) + 6'h01)
		else $error("link clock fall not counted in time");
	AST_SHIFT_ORDER: assert property (frame_bit_count != 6'h00 &&
		frame_bit_count != $past(frame_bit_count) |=>
		half_current_on[3] == $past(half_current_on[2]) &&
		tap_two_invert == $past(tap_one_invert))
		else $error("bits did not move one place per shift");
	AST_ACTIVE_FOLLOWS: assert property ($rose(serial_cfg_write_enable)
		|-> ##[2:4] frame_active)
		else $error("frame not opened after enable rose");
	AST_HOLD_WHEN_OFF: assert property (seq_quiet |=> $stable(ctl_bits))
		else $error("controls moved with enable low");
	AST_FRAME_DONE: assert property ($fell(serial_cfg_write_enable) &&
		frame_bit_count >= 6'h20 |-> ##[2:5] frame_complete)
		else $error("full frame not flagged complete");
	AST_SETTLE: assert property ($changed(ctl_bits) |-> since_fall <= 4'h6)
		else $error("controls changed late or without a link edge");
	AST_TAP2_WEIGHT: assert property (tap_two_weight == $countones(to_two))
		else $error("tap two weight wrong");
	AST_HOME_WEIGHT: assert property (
		tap_one_weight == $countones(home[1:0]) &&
		tap_three_weight == $countones(home[4:2]) &&
		tap_four_weight == $countones(home[6:5]))
		else $error("home tap weight wrong");
endmodule : stcl_chk

bind stcl_top stcl_chk stcl_chk_inst (.clock, .reset_n, .serial_cfg_data_in,
	.serial_cfg_clock_in, .serial_cfg_write_enable, .half_current_on,
	.analog_section_on, .data_output_buffer_on, .data_output_buffer_tap2,
	.clock_out_select, .short_delay_parallel, .long_delay_parallel,
	.tap_one_invert, .tap_two_invert, .tap_three_invert, .tap_four_invert,
	.tap_one_weight, .tap_two_weight, .tap_three_weight, .tap_four_weight,
	.frame_active, .frame_complete, .frame_bit_count);

// [testbench/stcl_ctrl_model.sv]
`timescale 1ns/1ps

// --------
// Configuration controller on the far side of the link
// --------
module stcl_ctrl_model (
	input  wire logic clock,
	output logic      serial_cfg_data_in,
	output logic      serial_cfg_clock_in,
	output logic      serial_cfg_write_enable
);
	// Link parks with its clock high and enable low between frames
	initial begin
		serial_cfg_data_in      = 1'b0;
		serial_cfg_clock_in     = 1'b1;
		serial_cfg_write_enable = 1'b0;
	end

	// Whole system cycles, so every change lands just after an edge
	task automatic pause(input int n);
		repeat (n) @(posedge clock);
	endtask : pause

	// Data set a half period ahead of the fall, held a half period after
	task automatic put_bit(input logic b, input int half);
		serial_cfg_data_in  <= b;
		pause(half);
		serial_cfg_clock_in <= 1'b0;
		pause(half);
		serial_cfg_clock_in <= 1'b1;
	endtask : put_bit

	// Junk bits first if asked, then the word, first bit first
	task automatic send_word(input logic [0:31] w, input int extra,
		input int half);
		int i;
		serial_cfg_write_enable <= 1'b1;
		pause(half);
		for (i = 0; i < extra; i++) begin
			put_bit(i[0], half);
		end
		for (i = 0; i < 32; i++) begin
			put_bit(w[i], half);
		end
		// Released data shows no stale value
		serial_cfg_data_in <= ~w[31];
		pause(half);
		serial_cfg_write_enable <= 1'b0;
		pause(half);
	endtask : send_word

	// Clock pulses with enable low; the loader must ignore them
	task automatic idle_clocks(input int n);
		int i;
		for (i = 0; i < n; i++) begin
			put_bit(i[0], 4);
		end
	endtask : idle_clocks
endmodule : stcl_ctrl_model

// [testbench/stcl_top_tb_top.sv]
`timescale 1ns/1ps
`include "stcl_cfg.svh"

module stcl_top_tb_top;
	// --------
	// Wires to the loader
	// --------
	logic                              clock;
	logic                              reset_n;
	logic                              serial_cfg_data_in;
	logic                              serial_cfg_clock_in;
	logic                              serial_cfg_write_enable;
	logic [`STCL_TAP_COUNT-1:0]        half_current_on;
	logic [`STCL_TAP_COUNT-1:0]        analog_section_on;
	logic [`STCL_DOB_COUNT-1:0]        data_output_buffer_on;
	logic [`STCL_DOB_COUNT-1:0]        data_output_buffer_tap2;
	logic                              clock_out_select;
	logic                              short_delay_parallel;
	logic                              long_delay_parallel;
	logic                              tap_one_invert;
	logic                              tap_two_invert;
	logic                              tap_three_invert;
	logic                              tap_four_invert;
	logic [`STCL_WEIGHT_BITS-1:0]      tap_one_weight;
	logic [`STCL_WEIGHT_BITS-1:0]      tap_two_weight;
	logic [`STCL_WEIGHT_BITS-1:0]      tap_three_weight;
	logic [`STCL_WEIGHT_BITS-1:0]      tap_four_weight;
	logic                              frame_active;
	logic                              frame_complete;
	logic [`STCL_COUNT_BITS-1:0]       frame_bit_count;
	int                                error_cnt = 0;
	int                                checks_done = 0;
	// Buffer groups on home taps, all on tap two, all ones, mixed
	logic [0:31] pats [4] = '{32'h00FE0000, 32'h00FEFE00,
		32'hFFFFFFFF, 32'h5AA5C33C};

	stcl_top stcl_top_inst (.clock, .reset_n, .serial_cfg_data_in,
		.serial_cfg_clock_in, .serial_cfg_write_enable, .half_current_on,
		.analog_section_on, .data_output_buffer_on, .data_output_buffer_tap2,
		.clock_out_select, .short_delay_parallel, .long_delay_parallel,
		.tap_one_invert, .tap_two_invert, .tap_three_invert, .tap_four_invert,
		.tap_one_weight, .tap_two_weight, .tap_three_weight, .tap_four_weight,
		.frame_active, .frame_complete, .frame_bit_count);
	stcl_ctrl_model stcl_ctrl_model_inst (.clock, .serial_cfg_data_in,
		.serial_cfg_clock_in, .serial_cfg_write_enable);

	// 100 MHz system clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// --------
	// Expected outputs from a word and an edge count
	// --------
	function automatic logic [47:0] expect_of(input logic [0:31] w,
		input logic [5:0] n);
		logic [3:0] hc, an;
		logic [6:0] on, t2;
		logic [2:0] wt [4];
		int i;
		for (i = 0; i < 4; i++) begin
			hc[i] = w[3 - i];
			an[i] = w[7 - i];
			wt[i] = 3'h0;
		end
		for (i = 0; i < 7; i++) begin
			on[i] = w[14 - i];
			t2[i] = w[22 - i];
			// Buffers one and two home on tap one, three to five on three
			if (on[i] && t2[i]) wt[1] += 3'h1;
			else if (on[i]) wt[i < 2 ? 0 : (i < 5 ? 2 : 3)] += 3'h1;
		end
		return {hc, an, on, t2, w[24], w[25], w[26], w[30], w[29], w[28],
			w[27], wt[0], wt[1], wt[2], wt[3], n >= 6'h20, n};
	endfunction : expect_of

	// Compare every output except frame_active once the last edge has long settled
	task automatic check(input logic [0:31] w, input logic [5:0] n);
		logic [47:0] got;
		repeat (6) @(posedge clock);
		#1;
		got = {half_current_on, analog_section_on, data_output_buffer_on,
			data_output_buffer_tap2, clock_out_select, short_delay_parallel,
			long_delay_parallel, tap_one_invert, tap_two_invert,
			tap_three_invert, tap_four_invert, tap_one_weight, tap_two_weight,
			tap_three_weight, tap_four_weight, frame_complete, frame_bit_count};
		checks_done++;
		if (got !== expect_of(w, n)) begin
			error_cnt++;
			$display("[ERR] controls exp %h got %h", expect_of(w, n), got);
		end
		@(posedge clock);
	endtask : check

	// Single exit for the tests and the watchdog
	task automatic report_and_stop();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	// --------
	// Test sequence
	// --------
	initial begin
		int i;
		reset_n = 1'b0;
		repeat (16) @(posedge clock);
		reset_n <= 1'b1;
		check(32'h0, 6'h00);
		// Walking one reaches every field and the unused bits
		for (i = 0; i < 32; i++) begin
			stcl_ctrl_model_inst.send_word(32'h80000000 >> i, 0, 4);
			check(32'h80000000 >> i, 6'h20);
		end
		// Fixed patterns; the second and fourth go out with a slower link clock
		for (i = 0; i < 4; i++) begin
			stcl_ctrl_model_inst.send_word(pats[i], 0, 4 + 2 * i[0]);
			check(pats[i], 6'h20);
		end
		stcl_ctrl_model_inst.send_word(32'hA5A5F00F, 8, 4);
		check(32'hA5A5F00F, 6'h28);
		stcl_ctrl_model_inst.idle_clocks(6);
		check(32'hA5A5F00F, 6'h28);
		reset_n <= 1'b0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		check(32'h0, 6'h00);
		report_and_stop();
	end

	// Whole run is near 10600 cycles; cut a hang well beyond that
	initial begin
		repeat (40000) @(posedge clock);
		error_cnt++;
		report_and_stop();
	end
endmodule : stcl_top_tb_top
